// ===== verilog/pic_params.svh
/*
 Timing constants and reset values for the preload interval counter.
 Assumes a single clock domain; included by bare name.
*/
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH
`define PIC_CNT_RST   8'h00
`define PIC_PRE_RST   8'h00
`define PIC_CNT_MAX   8'hff
`define PIC_SEL_MCLK  2'h0
`define PIC_SEL_ACLK  2'h1
`define PIC_SEL_PIN   2'h2
`define PIC_SEL_AND   2'h3
`endif

// ===== verilog/pic_pkg.sv
/*
 Types shared by the preload interval counter modules.
 Assumes nothing of its surroundings.
*/
package pic_pkg;
    // Clock source selection
    typedef enum logic [1:0] {
        PIC_SRC_MCLK = 2'h0,
        PIC_SRC_ACLK = 2'h1,
        PIC_SRC_PIN  = 2'h2,
        PIC_SRC_AND  = 2'h3
    } pic_src_t;
    // Start-bit hunt state
    typedef enum logic [0:0] {
        PIC_ST_RUN  = 1'b0,
        PIC_ST_HUNT = 1'b1
    } pic_st_t;
endpackage

// ===== verilog/pic_edge_if.sv
/*
 Carries source edge pulses and the receive pin level from the edge finder to the counter.
 Assumes one clock domain.
*/
`timescale 1ns/1ps
interface pic_edge_if;
    logic tick;      // One-cycle rising edge of the selected source
    logic rx_fall;   // One-cycle falling edge of the receive pin
    logic rx_level;  // Synchronised receive pin level
    modport src (output tick, output rx_fall, output rx_level);
    modport dst (input tick, input rx_fall, input rx_level);
endinterface

// ===== verilog/pic_edge.sv
/*
 Synchronises the auxiliary clock and receive pin and turns the selected
 source into one-cycle edge pulses. Assumes the aux clock and pin are slower than i_clk.
*/
`timescale 1ns/1ps
`include "pic_params.svh"
module pic_edge (
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    input  wire logic [1:0] i_sel,
    input  wire logic       i_aclk,
    input  wire logic       i_rx,
    pic_edge_if.src         e
);
    logic [1:0] a_sync_reg, a_sync_next;  // Aux clock synchroniser
    logic [1:0] r_sync_reg, r_sync_next;  // Receive pin synchroniser
    logic       a_prev_reg, a_prev_next;  // Previous aux level
    logic       r_prev_reg, r_prev_next;  // Previous pin level
    logic       m_prev_reg, m_prev_next;  // Previous pin level for rising-edge mode
    logic       lvl;                      // Selected level for pin modes

    // Next-state and edge decode
    always_comb begin
        a_sync_next = {a_sync_reg[0], i_aclk};
        r_sync_next = {r_sync_reg[0], i_rx};
        a_prev_next = a_sync_reg[1];
        r_prev_next = r_sync_reg[1];
        // Master clock is i_clk itself, so gating it with the pin gives one
        // rising edge per cycle while the pin is high, not one per pin edge
        lvl         = r_sync_reg[1];
        m_prev_next = lvl;
        e.rx_level  = r_sync_reg[1];
        e.rx_fall   = r_prev_reg & ~r_sync_reg[1];
        unique case (i_sel)
            `PIC_SEL_MCLK: e.tick = 1'b1;
            `PIC_SEL_ACLK: e.tick = a_sync_reg[1] & ~a_prev_reg;
            `PIC_SEL_PIN:  e.tick = lvl & ~m_prev_reg;
            `PIC_SEL_AND:  e.tick = lvl;
        endcase
    end

    // Register stage
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            a_sync_reg <= 2'h0;
            r_sync_reg <= 2'h3;
            a_prev_reg <= 1'b0;
            r_prev_reg <= 1'b1;
            m_prev_reg <= 1'b1;
        end else begin
            a_sync_reg <= a_sync_next;
            r_sync_reg <= r_sync_next;
            a_prev_reg <= a_prev_next;
            r_prev_reg <= r_prev_next;
            m_prev_reg <= m_prev_next;
        end
    end
endmodule

// ===== verilog/pic_top.sv
/*
 Preload interval counter with start-bit hunt and serial bit latches.
 Assumes software drives the control ports on i_clk and services the
 latches between carry pulses; pins arrive asynchronously.
*/
`timescale 1ns/1ps
`include "pic_params.svh"
module pic_top (
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    input  wire logic       i_aclk,            // Auxiliary clock, asynchronous
    input  wire logic       i_receive_pin_input, // Receive pin level
    input  wire logic [1:0] i_clk_sel,         // Clock source select
    input  wire logic       i_count_en,        // Count enable
    input  wire logic       i_start_hunt,      // Start-bit detection on
    input  wire logic       i_pre_wr,          // Preload write strobe
    input  wire logic [7:0] i_pre_wdata,       // Preload write data
    input  wire logic       i_cnt_wr,          // Counter write strobe (loads preload)
    input  wire logic       i_tx_bit,          // Next transmit bit from software
    input  wire logic       i_port_out,        // Ordinary port output value
    input  wire logic       i_port_dir,        // Ordinary port drives pin
    input  wire logic       i_tx_func,         // Pin 2 carries transmit function
    output logic [7:0]      o_preload,         // Preload readback
    output logic [7:0]      o_count,           // Counter readback
    output logic            o_carry,           // One-cycle carry-out pulse
    output logic            o_receive_bit_latch,
    output logic            o_transmit_bit_latch,
    output logic            o_hunting,         // Waiting for start bit
    output logic            o_transmit_pin_output, // Pin 2 output value
    output logic            o_transmit_pin_oe  // Pin 2 output enable
);
    pic_edge_if e ();

    logic [7:0]     pre_reg, pre_next;    // Preload buffer
    logic [7:0]     cnt_reg, cnt_next;    // Counter
    logic           cy_reg, cy_next;      // Carry pulse
    logic           rxl_reg, rxl_next;    // Receive bit latch
    logic           txl_reg, txl_next;    // Transmit bit latch
    logic           pin_reg, pin_next;    // Pin output value
    logic           oe_reg, oe_next;      // Pin output enable
    pic_pkg::pic_st_t st_reg, st_next;    // Hunt state
    logic           adv;                  // Counter advances this cycle
    logic           wrap;                 // Advance from all-ones

    pic_edge u_edge (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .i_sel  (i_clk_sel),
        .i_aclk (i_aclk),
        .i_rx   (i_receive_pin_input),
        .e      (e)
    );

    // Counter, preload and hunt next state
    always_comb begin
        pre_next = pre_reg;
        cnt_next = cnt_reg;
        st_next  = st_reg;
        if (i_pre_wr) begin
            pre_next = i_pre_wdata;
        end
        // idle in hunt until receive falls
        unique case (st_reg)
            pic_pkg::PIC_ST_HUNT: begin
                if (!i_start_hunt || e.rx_fall) begin
                    st_next = pic_pkg::PIC_ST_RUN;
                end
            end
            pic_pkg::PIC_ST_RUN: begin
                if (i_start_hunt && i_cnt_wr) begin
                    st_next = pic_pkg::PIC_ST_HUNT;
                end
            end
        endcase
        // count on source edge while enabled and not hunting
        adv  = i_count_en && e.tick && (st_reg == pic_pkg::PIC_ST_RUN) && !i_cnt_wr;
        wrap = adv && (cnt_reg == `PIC_CNT_MAX);
        // counter write takes the old preload value
        if (i_cnt_wr) begin
            cnt_next = pre_reg;
        end else if (adv) begin
            cnt_next = cnt_reg + 8'h01;
        end
        cy_next = wrap;
    end

    // Serial latches and shared pin next state
    always_comb begin
        rxl_next = rxl_reg;
        txl_next = txl_reg;
        if (wrap) begin
            rxl_next = e.rx_level;
            txl_next = i_tx_bit;
        end
        // pin carries transmit latch or ordinary port
        pin_next = i_tx_func ? txl_next : i_port_out;
        oe_next  = i_tx_func | i_port_dir;
    end

    // Register all state
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pre_reg <= `PIC_PRE_RST;
            cnt_reg <= `PIC_CNT_RST;
            cy_reg  <= 1'b0;
            rxl_reg <= 1'b1;
            txl_reg <= 1'b1;
            pin_reg <= 1'b1;
            oe_reg  <= 1'b0;
            st_reg  <= pic_pkg::PIC_ST_RUN;
        end else begin
            pre_reg <= pre_next;
            cnt_reg <= cnt_next;
            cy_reg  <= cy_next;
            rxl_reg <= rxl_next;
            txl_reg <= txl_next;
            pin_reg <= pin_next;
            oe_reg  <= oe_next;
            st_reg  <= st_next;
        end
    end

    assign o_preload            = pre_reg;
    assign o_count              = cnt_reg;
    assign o_carry              = cy_reg;
    assign o_receive_bit_latch  = rxl_reg;
    assign o_transmit_bit_latch = txl_reg;
    assign o_hunting            = (st_reg == pic_pkg::PIC_ST_HUNT);
    assign o_transmit_pin_output = pin_reg;
    assign o_transmit_pin_oe    = oe_reg;

    cnt_load_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_cnt_wr |=> o_count == $past(pre_reg))
        else $error("counter did not load preload");
    wrap_carry_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (adv && cnt_reg == 8'hff) |=> (o_carry && o_count == 8'h00))
        else $error("wrap without carry");
    hold_dis_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (!i_count_en && !i_cnt_wr) |=> $stable(o_count))
        else $error("count moved while disabled");
    hunt_idle_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (o_hunting && !i_cnt_wr) |=> $stable(o_count))
        else $error("counted during hunt");
    rx_latch_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !cy_next |=> $stable(o_receive_bit_latch))
        else $error("receive latch moved off carry");
    rx_sample_a: assert property (@(posedge i_clk) disable iff (i_srst)
        cy_next |=> o_receive_bit_latch == $past(e.rx_level))
        else $error("receive sample wrong");
    tx_latch_a: assert property (@(posedge i_clk) disable iff (i_srst)
        cy_next |=> o_transmit_bit_latch == $past(i_tx_bit))
        else $error("transmit latch wrong");
    pre_buf_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_pre_wr && !i_cnt_wr && !adv) |=> ($stable(o_count) && o_preload == $past(i_pre_wdata)))
        else $error("preload disturbed count");
    // pin follows transmit latch in transmit mode
    pin_share_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_tx_func |=> (o_transmit_pin_oe && o_transmit_pin_output == o_transmit_bit_latch))
        else $error("pin not carrying transmit");

    // Some checks below watch the edge pulses from u_edge directly; a fault
    // in the source selector shows up here only as a wrong count
    // preload takes written value
    pre_load_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_pre_wr |=> o_preload == $past(i_pre_wdata))
        else $error("preload write lost");
    count_en_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_count_en && e.tick && !o_hunting && !i_cnt_wr) |=> o_count == $past(o_count) + 8'h01)
        else $error("count did not advance");
    carry_pulse_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_carry |=> !o_carry)
        else $error("carry longer than one cycle");
    hunt_arm_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (!o_hunting && i_start_hunt && i_cnt_wr) |=> o_hunting)
        else $error("hunt not armed");
    hunt_stay_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (o_hunting && i_start_hunt && !e.rx_fall) |=> o_hunting)
        else $error("hunt left without start edge");
    hunt_leave_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (o_hunting && e.rx_fall) |=> !o_hunting)
        else $error("start edge missed");
    // transmit latch only moves on carry
    tx_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !cy_next |=> $stable(o_transmit_bit_latch))
        else $error("transmit latch moved off carry");
    port_pin_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_tx_func |=> (o_transmit_pin_oe == $past(i_port_dir)
            && o_transmit_pin_output == $past(i_port_out)))
        else $error("pin not carrying port");
    mclk_src_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_clk_sel == `PIC_SEL_MCLK && i_count_en && !o_hunting && !i_cnt_wr)
            |=> o_count == $past(o_count) + 8'h01)
        else $error("master clock source missed a cycle");
    // gated clock counts while pin high
    and_src_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_clk_sel == `PIC_SEL_AND && e.rx_level && i_count_en && !o_hunting && !i_cnt_wr)
            |=> o_count == $past(o_count) + 8'h01)
        else $error("gated source missed a cycle");
    // gated clock stops while pin low
    and_gate_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_clk_sel == `PIC_SEL_AND && !e.rx_level && !i_cnt_wr) |=> $stable(o_count))
        else $error("gated source counted with pin low");
endmodule

// ===== tb/pic_line_peer.sv
/*
 Far-side serial peer: drives the receive pin and watches the transmit pin.
 Assumes the bench clock; the line idles high as a UART line does.
*/
`timescale 1ns/1ps
module pic_line_peer (
    input  wire logic i_clk,
    input  wire logic i_tx_pin,
    input  wire logic i_tx_oe,
    output logic      o_rx,
    output logic      o_line
);
    initial o_rx = 1'b1;
    // A released pin floats to the idle level through the line's pull-up
    assign o_line = i_tx_oe ? i_tx_pin : 1'b1;
    // Hold the line at one level for n cycles
    task automatic hold(input logic v, input int n);
        o_rx <= v;
        repeat (n) @(posedge i_clk);
    endtask
    // Slow pulses, one rising edge each, so the synchroniser sees them all
    task automatic pulses(input int n);
        repeat (n) begin
            hold(1'b0, 3);
            hold(1'b1, 3);
        end
    endtask
endmodule

// ===== tb/tb_pic_top.sv
/*
 Self-checking bench for the preload interval counter with a cycle model.
 Assumes the design files and the line peer are compiled first.
*/
`timescale 1ns/1ps
module tb_pic_top;
    logic        i_clk, i_srst, i_aclk, rx, en, hunt, pre_wr, cnt_wr, tx_bit, chk_on;
    logic        p_out, p_dir, tx_func, carry, rxl, txl, hunting, pin, oe, seen_line;
    logic        e_car, e_rxl, e_txl; // Model carry and latches
    logic [1:0]  sel;
    logic [7:0]  wdata, pre, cnt, e_cnt, e_pre;
    logic [31:0] seed, r;
    int          error_cnt, total_checks;
    pic_top uut (.i_clk(i_clk), .i_srst(i_srst), .i_aclk(i_aclk),
        .i_receive_pin_input(rx), .i_clk_sel(sel), .i_count_en(en),
        .i_start_hunt(hunt), .i_pre_wr(pre_wr), .i_pre_wdata(wdata),
        .i_cnt_wr(cnt_wr), .i_tx_bit(tx_bit), .i_port_out(p_out),
        .i_port_dir(p_dir), .i_tx_func(tx_func), .o_preload(pre), .o_count(cnt),
        .o_carry(carry), .o_receive_bit_latch(rxl), .o_transmit_bit_latch(txl),
        .o_hunting(hunting), .o_transmit_pin_output(pin), .o_transmit_pin_oe(oe));
    pic_line_peer peer (.i_clk(i_clk), .i_tx_pin(pin), .i_tx_oe(oe), .o_rx(rx),
        .o_line(seen_line));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Bounded wait for a carry (w=1) or for the hunt to end (w=0)
    task automatic wait_on(input logic w, input int lim);
        for (int k = 0; k < lim; k++) begin
            @(posedge i_clk);
            #1;
            if (w ? carry === 1'b1 : hunting === 1'b0) return;
        end
        error_cnt++;
        $display("unexpected timeout expected %0d seen %0d", w, ~w);
        stop_test();
    endtask
    // Cycle model of the counter, fed with the same sampled inputs
    always @(posedge i_clk) begin
        e_car <= 1'b0;
        if (i_srst) begin
            e_cnt <= 8'h00;
            e_pre <= 8'h00;
            e_rxl <= 1'b1;
            e_txl <= 1'b1;
        end else begin
            if (pre_wr) e_pre <= wdata;
            if (cnt_wr) e_cnt <= e_pre; // Old preload wins on a shared cycle
            else if (en && sel == 2'h0) begin
                e_cnt <= e_cnt + 8'h01;
                if (e_cnt == 8'hff) begin
                    e_car <= 1'b1;
                    e_rxl <= rx;
                    e_txl <= tx_bit;
                end
            end
        end
    end
    // Compare the model with the design on every cycle it is valid
    always @(negedge i_clk) if (chk_on) begin
        check("count", e_cnt, cnt);
        check("preload", e_pre, pre);
        check("flags", {5'h00, e_car, e_rxl, e_txl}, {5'h00, carry, rxl, txl});
    end
    initial begin
        seed = 32'h3715;
        {error_cnt, total_checks} = '0;
        {i_srst, chk_on, i_aclk, en, hunt, pre_wr, cnt_wr, tx_bit} = 8'h80;
        {p_out, p_dir, tx_func, sel, wdata} = '0;
        tick(2);
        i_srst <= 1'b0;
        chk_on <= 1'b1;
        #1;
        check("reset pins", {5'h00, hunting, oe, pin}, 8'h01);
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            tick(1);
            {tx_func, p_out, p_dir} <= r[12:10];
            pre_wr <= 1'b1;
            wdata <= r[7:0] | 8'hf8;
            cnt_wr <= r[9];
            tick(1);
            pre_wr <= 1'b0;
            cnt_wr <= 1'b1;
            tick(1);
            {cnt_wr, en, pre_wr, tx_bit} <= {3'b011, r[8]};
            wdata <= r[23:16];
            tick(1);
            pre_wr <= 1'b0;
            wait_on(1'b1, 300);
            tick(1);
            en <= 1'b0;
            tick(3);
            #1;
            check("pin", {7'h00, tx_func ? e_txl : p_out}, {7'h00, pin});
            check("oe", {7'h00, tx_func | p_dir}, {7'h00, oe});
            check("line", {7'h00, tx_func ? e_txl : (p_dir ? p_out : 1'b1)},
                {7'h00, seen_line});
        end
        $display("test count done");
        chk_on <= 1'b0;
        for (int s = 1; s < 4; s++) begin
            peer.hold(1'b0, 4); // Line low so the gated source starts quiet
            {sel, en, pre_wr} <= {s[1:0], 2'b11};
            wdata <= 8'hf0;
            tick(1);
            {pre_wr, cnt_wr} <= 2'b01;
            tick(1);
            cnt_wr <= 1'b0;
            if (s == 1) repeat (s + 2) begin
                i_aclk <= 1'b1;
                tick(3);
                i_aclk <= 1'b0;
                tick(3);
            end else if (s == 2) begin
                peer.pulses(s + 2);
            end else begin
                // Gated master clock counts every cycle the line is high
                peer.hold(1'b1, s + 2);
                peer.hold(1'b0, 1);
            end
            tick(4);
            #1;
            check("source count", 8'hf0 + 8'(s + 2), cnt);
        end
        $display("test source done");
        peer.hold(1'b1, 4); // Line back to idle before the hunt
        {sel, hunt, cnt_wr} <= 4'b0011;
        tick(1);
        cnt_wr <= 1'b0;
        tick(5);
        #1;
        check("hunting", 8'h01, {7'h00, hunting});
        check("held count", 8'hf0, cnt);
        peer.hold(1'b0, 1);
        wait_on(1'b0, 8);
        wait_on(1'b1, 40);
        check("first sample", 8'h00, {7'h00, rxl});
        {hunt, en} <= 2'b00;
        peer.hold(1'b1, 4);
        $display("test hunt done");
        stop_test();
    end
endmodule
